// ==== rtl/ssrb_consts.svh ====
// constants for the spindle serial register bank
`ifndef SSRB_CONSTS_SVH
`define SSRB_CONSTS_SVH

// register addresses carried in the first four frame bits
`define SSRB_ADDR_SPIN 4'h0
`define SSRB_ADDR_SYS 4'h1
`define SSRB_ADDR_STATUS 4'h2

// frame layout
`define SSRB_FRAME_BITS 5'h10
`define SSRB_ADDR_BITS 5'h04

// spin current control fields
`define SSRB_SP_DAC_MSB 7
`define SSRB_SP_RANGE 8

// system control fields
`define SSRB_SC_SLEEP 0
`define SSRB_SC_BRAKE 1
`define SSRB_SC_PWM 2
`define SSRB_SC_SINGLE 3
`define SSRB_SC_CLKEN 4
`define SSRB_SC_CNTRUN 5
`define SSRB_SC_DETOE 6
`define SSRB_SC_HALF 7
`define SSRB_SC_NEG 8
`define SSRB_SC_MASK2X 9
`define SSRB_SC_TESTA 10
`define SSRB_SC_TESTB 11

// reset values
`define SSRB_SPIN_RST 9'h000
`define SSRB_SYS_RST 12'h000
`define SSRB_STATUS_RST 8'h00
`define SSRB_GRAY_RST 3'h0

// masking interval in internal clock ticks
`define SSRB_MASK_SHORT 11'h0200
`define SSRB_MASK_LONG 11'h0400

// synchroniser idle values: select and power-on reset sit high
`define SSRB_SYNC_INIT 11'h0012

`endif

// ==== rtl/ssrb_pkg.sv ====
// types shared by the spindle serial register bank
package ssrb_pkg;

  // serial port state, gray coded along idle -> input -> output
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_INPUT = 2'b01,
    SP_OUTPUT = 2'b11
  } ssrb_state_type;

endpackage : ssrb_pkg

// ==== rtl/ssrb_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module ssrb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // raw pins and filtered levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // stage1 feeds stage2 only; a level counts once stage2 and stage3 agree
  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      dout <= INIT;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout <= (stage2 & ~(stage2 ^ stage3)) | (dout & (stage2 ^ stage3));
    end
  end

endmodule : ssrb_sync
`default_nettype wire

// ==== rtl/ssrb_top.sv ====
// spindle driver serial port and control/status register bank
//
// Notes on behaviour
// - spin register bits 7..0 hold the current limit dac code, bit 0 lsb.
// - spin register bit 8 picks loop gain range, 0 is 4:1, 1 is 20:1.
// - spindle outputs float while system control bit 0 is zero.
// - system control bit 1 turns on all three lower drivers to brake.
// - system control bit 2 picks pwm when one, linear when zero.
// - bit 3 one watches phase a only, zero watches all three phases.
// - spin clock pulses advance the commutation counter only while bit 4 is one.
// - commutation counter held in reset while bit 5 is zero.
// - detect output pin floats while bit 6 is zero, driven while one.
// - bit 7 zero runs logic at full rate, one at half rate.
// - negative supply circuitry enabled only while bit 8 is one.
// - bit 9 sets masking to 512 ticks when zero, 1024 when one.
// - status bits 0, 1, 2 report zero crossings on phases a, b, c.
// - status bits 3, 4, 5 show gray counter bits x, y, z.
// - status bit 6 shows the overheat warning.
// - status bit 7 shows the loopback comparator while pwm bit is zero.
// - every access is sixteen bits; fewer bits leave it incomplete.
// - four address bits then twelve data bits; 0, 1, 2 pick the registers.
// - a read of the status address shifts out twelve data bits, one per clock.
// - power-on reset low returns every register field to zero.
// - no braking after reset until the host commands it.
// - write with select and direction low; update only after all sixteen bits.
// - select high clears port state, floats data, aborts a write.
// - direction rising loads the register; shift out lsb first, then zeros.
// - drive data only with select low and direction high; float when deselected.
`timescale 1ns/1ns
`default_nettype none
`include "ssrb_consts.svh"
module ssrb_top (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // power-on reset pin
  input wire logic por_n,
  // serial port pins
  input wire logic serial_clock,
  input wire logic serial_select_n,
  input wire logic read_write,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  // spindle sense pins
  input wire logic spin_clock,
  input wire logic [2:0] zero_cross_raw,
  input wire logic overheat_warning,
  input wire logic loopback_raw,
  // spin current controls
  output logic [7:0] dac_code,
  output logic gain_range_high,
  // system controls
  output logic spindle_hiz,
  output logic lower_drive_on,
  output logic pwm_mode,
  output logic single_phase_detect,
  output logic commutation_counter_reset_n,
  output logic half_rate_select,
  output logic negative_supply_enable,
  output logic mask_interval_double,
  output logic test_control_a,
  output logic test_control_b,
  // internal timing and commutation
  output logic logic_tick,
  output logic [2:0] commutation_state,
  // detect output pin
  output logic zero_cross_detect_output,
  output logic zero_cross_detect_oe_n
);

  // synchronised pins
  logic [10:0] pin_lvl;
  logic sclk_prev;
  logic rw_prev;
  logic spin_prev;
  logic [2:0] zc_prev;

  // port and register state
  ssrb_pkg::ssrb_state_type state;
  ssrb_pkg::ssrb_state_type next_state;
  logic [4:0] bit_count;
  logic [15:0] shreg;
  logic [3:0] addr_hold;
  logic addr_seen;
  logic [8:0] spin_ctl;
  logic [11:0] sys_ctl;
  logic [7:0] status_word;
  logic half_phase;
  logic spin_pend;
  logic [10:0] mask_count;
  logic [2:0] zc_seen;

  ssrb_sync #(
    .W(11),
    .INIT(`SSRB_SYNC_INIT)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .din({loopback_raw, overheat_warning, zero_cross_raw, spin_clock, por_n,
          sdio_in, read_write, serial_select_n, serial_clock}),
    .dout(pin_lvl)
  );

  // filtered pin levels and edges
  wire sclk_f = pin_lvl[0];
  wire sel_f = pin_lvl[1];
  wire rw_f = pin_lvl[2];
  wire sdio_f = pin_lvl[3];
  wire por_f = pin_lvl[4];
  wire spin_f = pin_lvl[5];
  wire [2:0] zc_f = pin_lvl[8:6];
  wire heat_f = pin_lvl[9];
  wire loop_f = pin_lvl[10];
  wire sclk_rise = sclk_f & ~sclk_prev;
  wire rw_rise = rw_f & ~rw_prev;
  wire spin_rise = spin_f & ~spin_prev;
  wire blk_rst = srst | ~por_f;

  // serial decode; frames arrive lsb first, address bits leading
  wire in_shift = (state == ssrb_pkg::SP_INPUT) && !sel_f && !rw_f && sclk_rise
                  && (bit_count != `SSRB_FRAME_BITS);
  wire out_shift = (state == ssrb_pkg::SP_OUTPUT) && !sel_f && rw_f && sclk_rise;
  wire [15:0] shifted_in = {sdio_f, shreg[15:1]};
  wire addr_done = in_shift && (bit_count == `SSRB_ADDR_BITS - 5'h01);
  wire frame_done = in_shift && (bit_count == `SSRB_FRAME_BITS - 5'h01);
  wire [3:0] frame_addr = shifted_in[3:0];
  wire [11:0] frame_data = shifted_in[15:4];
  wire wr_spin = frame_done && (frame_addr == `SSRB_ADDR_SPIN);
  wire wr_sys = frame_done && (frame_addr == `SSRB_ADDR_SYS);
  wire wr_bad = frame_done && !wr_spin && !wr_sys;
  // only the first four bits count as the read address
  wire load_status = rw_rise && !sel_f && addr_seen
                     && (addr_hold == `SSRB_ADDR_STATUS);
  wire drive_now = !sel_f && rw_f;

  // commutation and masking decode
  wire cnt_run = sys_ctl[`SSRB_SC_CNTRUN];
  wire step = logic_tick && (spin_pend || spin_rise)
              && sys_ctl[`SSRB_SC_CLKEN] && cnt_run;
  wire [2:0] phase_en = sys_ctl[`SSRB_SC_SINGLE] ? 3'h1 : 3'h7;
  wire mask_open = (mask_count == 11'h0000);
  wire [2:0] zc_hit = (zc_f ^ zc_prev) & phase_en & {3{mask_open}};
  wire [10:0] mask_load = sys_ctl[`SSRB_SC_MASK2X] ? `SSRB_MASK_LONG
                                                  : `SSRB_MASK_SHORT;
  wire next_tick = ~sys_ctl[`SSRB_SC_HALF] | half_phase;
  wire loop_bit = loop_f & ~sys_ctl[`SSRB_SC_PWM];
  // x in bit 3, y in bit 4, z in bit 5
  wire [7:0] next_status = {loop_bit, heat_f, commutation_state, zc_seen};

  // six-step gray sequence; a cleared counter enters at the first step
  function automatic logic [2:0] gray_next(input logic [2:0] cur);
    case (cur)
      3'h1: gray_next = 3'h3;
      3'h3: gray_next = 3'h2;
      3'h2: gray_next = 3'h6;
      3'h6: gray_next = 3'h4;
      3'h4: gray_next = 3'h5;
      default: gray_next = 3'h1;
    endcase
  endfunction : gray_next

  // port state follows select and direction
  always_comb begin
    next_state = state;
    case (state)
      ssrb_pkg::SP_IDLE: begin
        if (!sel_f) begin
          next_state = rw_f ? ssrb_pkg::SP_OUTPUT : ssrb_pkg::SP_INPUT;
        end
      end
      ssrb_pkg::SP_INPUT: begin
        if (sel_f) begin
          next_state = ssrb_pkg::SP_IDLE;
        end else if (rw_f) begin
          next_state = ssrb_pkg::SP_OUTPUT;
        end
      end
      ssrb_pkg::SP_OUTPUT: begin
        if (sel_f) begin
          next_state = ssrb_pkg::SP_IDLE;
        end else if (!rw_f) begin
          next_state = ssrb_pkg::SP_INPUT;
        end
      end
      default: next_state = ssrb_pkg::SP_IDLE;
    endcase
  end

  // edge history; tracks pins through power-on reset so no false edge follows its release
  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_prev <= 1'b0;
      rw_prev <= 1'b0;
      spin_prev <= 1'b0;
      zc_prev <= 3'h0;
    end else begin
      sclk_prev <= sclk_f;
      rw_prev <= rw_f;
      spin_prev <= spin_f;
      zc_prev <= zc_f;
    end
  end

  // serial port: deselect wipes the count but keeps shreg for read back
  always_ff @(posedge mclk) begin
    if (blk_rst || sel_f) begin
      state <= ssrb_pkg::SP_IDLE;
      bit_count <= 5'h00;
      addr_seen <= 1'b0;
    end else begin
      state <= next_state;
      if (in_shift) begin
        bit_count <= bit_count + 5'h01;
      end
      if (addr_done) begin
        addr_seen <= 1'b1;
      end
    end
  end

  // shift register and held address
  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      shreg <= 16'h0000;
      addr_hold <= 4'h0;
    end else begin
      if (load_status) begin
        shreg <= {8'h00, status_word};
      end else if (out_shift) begin
        shreg <= {1'b0, shreg[15:1]};
      end else if (in_shift) begin
        shreg <= shifted_in;
      end
      if (addr_done) begin
        addr_hold <= shifted_in[15:12];
      end
    end
  end

  // data pin: driven only when selected for output
  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      sdio_out <= 1'b0;
      sdio_oe_n <= 1'b1;
    end else begin
      sdio_out <= shreg[0];
      sdio_oe_n <= ~drive_now;
    end
  end

  // writable registers; other addresses fall through untouched
  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      spin_ctl <= `SSRB_SPIN_RST;
      sys_ctl <= `SSRB_SYS_RST;
    end else begin
      if (wr_spin) begin
        spin_ctl <= frame_data[8:0];
      end
      if (wr_sys) begin
        sys_ctl <= frame_data;
      end
    end
  end

  // half rate divider; ticks run continuously at full rate
  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      half_phase <= 1'b0;
      logic_tick <= 1'b0;
    end else begin
      half_phase <= ~half_phase;
      logic_tick <= next_tick;
    end
  end

  // commutation counter; a pulse seen between ticks waits for the next one
  always_ff @(posedge mclk) begin
    if (blk_rst || !cnt_run) begin
      commutation_state <= `SSRB_GRAY_RST;
      spin_pend <= 1'b0;
    end else begin
      spin_pend <= (spin_pend & ~step) | (spin_rise & ~step);
      if (step) begin
        commutation_state <= gray_next(commutation_state);
      end
    end
  end

  // masking after each step; hits are blind until it runs out
  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      mask_count <= 11'h0000;
      zc_seen <= 3'h0;
    end else begin
      if (step) begin
        mask_count <= mask_load;
      end else if (logic_tick && !mask_open) begin
        mask_count <= mask_count - 11'h0001;
      end
      // a hit in the clearing cycle survives
      zc_seen <= (step ? 3'h0 : zc_seen) | zc_hit;
    end
  end

  // status snapshot read by the port
  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      status_word <= `SSRB_STATUS_RST;
    end else begin
      status_word <= next_status;
    end
  end

  // control outputs, one flop each
  always_ff @(posedge mclk) begin
    if (blk_rst) begin
      dac_code <= 8'h00;
      gain_range_high <= 1'b0;
      spindle_hiz <= 1'b1;
      lower_drive_on <= 1'b0;
      pwm_mode <= 1'b0;
      single_phase_detect <= 1'b0;
      commutation_counter_reset_n <= 1'b0;
      half_rate_select <= 1'b0;
      negative_supply_enable <= 1'b0;
      mask_interval_double <= 1'b0;
      test_control_a <= 1'b0;
      test_control_b <= 1'b0;
      zero_cross_detect_output <= 1'b0;
      zero_cross_detect_oe_n <= 1'b1;
    end else begin
      dac_code <= spin_ctl[`SSRB_SP_DAC_MSB:0];
      gain_range_high <= spin_ctl[`SSRB_SP_RANGE];
      spindle_hiz <= ~sys_ctl[`SSRB_SC_SLEEP];
      lower_drive_on <= sys_ctl[`SSRB_SC_BRAKE];
      pwm_mode <= sys_ctl[`SSRB_SC_PWM];
      single_phase_detect <= sys_ctl[`SSRB_SC_SINGLE];
      commutation_counter_reset_n <= cnt_run;
      half_rate_select <= sys_ctl[`SSRB_SC_HALF];
      negative_supply_enable <= sys_ctl[`SSRB_SC_NEG];
      mask_interval_double <= sys_ctl[`SSRB_SC_MASK2X];
      test_control_a <= sys_ctl[`SSRB_SC_TESTA];
      test_control_b <= sys_ctl[`SSRB_SC_TESTB];
      zero_cross_detect_output <= |zc_seen;
      zero_cross_detect_oe_n <= ~sys_ctl[`SSRB_SC_DETOE];
    end
  end

  // checks, all on mclk
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (blk_rst);

  sequence s_sys_write;
    frame_done && (frame_addr == `SSRB_ADDR_SYS);
  endsequence

  sequence s_read_start;
    rw_rise && !sel_f && addr_seen && (addr_hold == `SSRB_ADDR_STATUS);
  endsequence

  a_sleep_float: assert property (
    ##1 (spindle_hiz == !$past(sys_ctl[`SSRB_SC_SLEEP])))
    else $error("spindle float does not follow sleep bit");

  a_brake_drive: assert property (
    $rose(sys_ctl[`SSRB_SC_BRAKE]) |=> lower_drive_on ##1 lower_drive_on)
    else $error("brake bit did not turn on lower drivers");

  a_sys_commit: assert property (
    s_sys_write |=> (sys_ctl == $past(frame_data)) ##1
    (negative_supply_enable == sys_ctl[`SSRB_SC_NEG]))
    else $error("system control write not committed");

  a_bad_address: assert property (
    wr_bad |=> $stable(sys_ctl) && $stable(spin_ctl))
    else $error("write to unknown address changed a register");

  a_counter_held: assert property (
    !cnt_run |=> (commutation_state == `SSRB_GRAY_RST))
    else $error("commutation counter not held in reset");

  a_spin_gate: assert property (
    !$past(sys_ctl[`SSRB_SC_CLKEN]) && $past(cnt_run) |-> $stable(commutation_state))
    else $error("counter advanced while spin clock disabled");

  a_gray_step: assert property (
    step |=> ($countones(commutation_state ^ $past(commutation_state)) == 1))
    else $error("commutation step changed more than one bit");

  a_mask_load: assert property (
    step |=> (mask_count == ($past(sys_ctl[`SSRB_SC_MASK2X]) ? `SSRB_MASK_LONG
                                                             : `SSRB_MASK_SHORT)))
    else $error("masking interval loaded wrong");

  a_read_load: assert property (
    s_read_start |=> (shreg[7:0] == $past(status_word)) && (shreg[15:8] == 8'h00)
    ##1 (sdio_out == $past(shreg[0])))
    else $error("status not loaded for read");

  a_deselect_float: assert property (
    sel_f |=> sdio_oe_n && (bit_count == 5'h00))
    else $error("deselect did not float data and clear count");

  a_drive_cause: assert property (
    !sdio_oe_n |-> !$past(sel_f) && $past(rw_f))
    else $error("data driven without read selection");

endmodule : ssrb_top
`default_nettype wire

// ==== dv/ssrb_host.sv ====
// host model for the serial port: select, direction, clock and data pins
`timescale 1ns/1ns
`default_nettype none
module ssrb_host (
  // clock
  input wire logic mclk,
  // device side of the data pin
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  // serial pins
  output logic serial_clock,
  output logic serial_select_n,
  output logic read_write,
  output logic sdio_in
);
  logic host_bit = 1'b0;
  logic host_en = 1'b0;
  logic last = 1'b0;

  // pins start deselected
  initial begin
    serial_clock = 1'b0;
    serial_select_n = 1'b1;
    read_write = 1'b0;
  end

  // a released line shows the inverse of its last level, so stale data never passes
  always @(negedge mclk) begin
    if (!sdio_oe_n) last <= sdio_out;
    else if (host_en) last <= host_bit;
  end
  assign sdio_in = !sdio_oe_n ? sdio_out : (host_en ? host_bit : ~last);

  // levels stand 6 mclk, above what the pin synchroniser needs
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask : hold

  task automatic pulse();
    serial_clock = 1'b1;
    hold(6);
    serial_clock = 1'b0;
    hold(6);
  endtask : pulse

  // frame bits go out lsb first
  task automatic put_bits(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      host_bit = bits[i];
      pulse();
    end
  endtask : put_bits

  // write frame; n below 16 leaves it short before deselect
  task automatic write_frame(input logic [3:0] addr, input logic [11:0] data, input int n);
    serial_select_n = 1'b0;
    read_write = 1'b0;
    host_en = 1'b1;
    hold(6);
    put_bits({data, addr}, n);
    host_en = 1'b0;
    serial_select_n = 1'b1;
    hold(8);
  endtask : write_frame

  // read frame: address, direction rise, then twelve data clocks
  task automatic read_frame(input logic [3:0] addr, output logic [11:0] q);
    serial_select_n = 1'b0;
    read_write = 1'b0;
    host_en = 1'b1;
    hold(6);
    put_bits({12'h000, addr}, 4);
    host_en = 1'b0;
    read_write = 1'b1;
    hold(10);
    for (int i = 0; i < 12; i++) begin
      q[i] = sdio_in;
      pulse();
    end
    read_write = 1'b0;
    serial_select_n = 1'b1;
    hold(8);
  endtask : read_frame
endmodule : ssrb_host
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the spindle serial register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic por_n = 1'b1;
  logic spin_clock = 1'b0;
  logic [2:0] zero_cross_raw = 3'h0;
  logic overheat_warning = 1'b0;
  logic loopback_raw = 1'b0;
  wire logic serial_clock, serial_select_n, read_write, sdio_in, sdio_out, sdio_oe_n;
  wire logic [7:0] dac_code;
  wire logic gain_range_high, spindle_hiz, lower_drive_on, pwm_mode, single_phase_detect;
  wire logic commutation_counter_reset_n, half_rate_select, negative_supply_enable;
  wire logic mask_interval_double, test_control_a, test_control_b, logic_tick;
  wire logic [2:0] commutation_state;
  wire logic zero_cross_detect_output, zero_cross_detect_oe_n;
  int err_count = 0;
  int checks_done = 0;
  int seed = 32'h4c2b;
  logic [11:0] exp_q[$];
  string name_q[$];
  logic [11:0] obs_q[$];
  logic [11:0] rd;
  logic [11:0] wr;
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  event obs_ev;

  // register images rebuilt from the control pins; clock enable has no pin
  wire logic [11:0] spin_obs = {3'h0, gain_range_high, dac_code};
  wire logic [11:0] sys_obs = {test_control_b, test_control_a, mask_interval_double,
    negative_supply_enable, half_rate_select, ~zero_cross_detect_oe_n,
    commutation_counter_reset_n, 1'b0, single_phase_detect, pwm_mode, lower_drive_on,
    ~spindle_hiz};

  // 50 MHz
  always #10 mclk = ~mclk;

  ssrb_top u_ssrb_top (.mclk(mclk), .srst(srst), .por_n(por_n),
    .serial_clock(serial_clock), .serial_select_n(serial_select_n),
    .read_write(read_write), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .spin_clock(spin_clock), .zero_cross_raw(zero_cross_raw),
    .overheat_warning(overheat_warning), .loopback_raw(loopback_raw),
    .dac_code(dac_code), .gain_range_high(gain_range_high), .spindle_hiz(spindle_hiz),
    .lower_drive_on(lower_drive_on), .pwm_mode(pwm_mode),
    .single_phase_detect(single_phase_detect),
    .commutation_counter_reset_n(commutation_counter_reset_n),
    .half_rate_select(half_rate_select), .negative_supply_enable(negative_supply_enable),
    .mask_interval_double(mask_interval_double), .test_control_a(test_control_a),
    .test_control_b(test_control_b), .logic_tick(logic_tick),
    .commutation_state(commutation_state),
    .zero_cross_detect_output(zero_cross_detect_output),
    .zero_cross_detect_oe_n(zero_cross_detect_oe_n));

  ssrb_host u_ssrb_host (.mclk(mclk), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .serial_clock(serial_clock), .serial_select_n(serial_select_n),
    .read_write(read_write), .sdio_in(sdio_in));

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // note the expected value, then hand the observation to the monitor
  task automatic note(input string what, input logic [11:0] exp, input logic [11:0] seen);
    exp_q.push_back(exp);
    name_q.push_back(what);
    obs_q.push_back(seen);
    -> obs_ev;
  endtask : note

  // monitor: each observation against the oldest note
  // several notes in one time step are drained together, so stimulus keeps its edge
  always begin
    @(obs_ev);
    while (obs_q.size() > 0) begin
      if (exp_q.size() == 0) begin
        obs_q.delete();
        check("queue", 12'h001, 12'h000);
      end else begin
        check(name_q.pop_front(), obs_q.pop_front(), exp_q.pop_front());
      end
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic wr_sys(input logic [11:0] d);
    u_ssrb_host.write_frame(4'h1, d, 16);
  endtask : wr_sys

  // one spin clock pulse, each level held 6 mclk
  task automatic step();
    spin_clock = 1'b1;
    repeat (6) @(negedge mclk);
    spin_clock = 1'b0;
    repeat (6) @(negedge mclk);
  endtask : step

  // run limit; a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    repeat (6) @(negedge mclk);
    note("spin", 12'h000, spin_obs);
    note("sys", 12'h000, sys_obs);
    note("sdio_oe_n", 12'h001, {11'h0, sdio_oe_n});
    for (int i = 0; i < 8; i++) begin
      wr = 12'($random(seed));
      u_ssrb_host.write_frame(4'h0, wr, 16);
      note("spin", {3'h0, wr[8:0]}, spin_obs);
      wr = 12'($random(seed));
      wr_sys(wr);
      note("sys", wr & 12'hfef, sys_obs);
    end
    // short frame aborted by deselect, then every non-writable address
    u_ssrb_host.write_frame(4'h1, ~wr, 15);
    note("sys", wr & 12'hfef, sys_obs);
    for (int a = 2; a < 16; a++) begin
      u_ssrb_host.write_frame(4'(a), ~wr, 16);
      note("sys", wr & 12'hfef, sys_obs);
    end
    // half rate ticks alternate, full rate stays high
    wr_sys(12'h081);
    rd[0] = logic_tick;
    @(negedge mclk);
    note("tick", {11'h0, ~rd[0]}, {11'h0, logic_tick});
    wr_sys(12'h030);
    note("tick", 12'h001, {11'h0, logic_tick});
    // status reads with warning and loopback, in linear mode then pwm mode
    overheat_warning = 1'b1;
    loopback_raw = 1'($random(seed));
    u_ssrb_host.read_frame(4'h2, rd);
    note("status", {4'h0, loopback_raw, 7'h40}, rd);
    note("sdio_oe_n", 12'h001, {11'h0, sdio_oe_n});
    wr_sys(12'h034);
    loopback_raw = 1'b1;
    u_ssrb_host.read_frame(4'h2, rd);
    note("status", 12'h040, rd);
    // gray count through a full turn
    for (int i = 0; i < 7; i++) begin
      step();
      note("gray", {9'h0, seq[i % 6]}, {9'h0, commutation_state});
    end
    u_ssrb_host.read_frame(4'h2, rd);
    note("status", 12'h048, rd);
    wr_sys(12'h024);
    step();
    note("gray", 12'h001, {9'h0, commutation_state});
    wr_sys(12'h014);
    note("gray", 12'h000, {9'h0, commutation_state});
    note("detect_oe_n", 12'h001, {11'h0, zero_cross_detect_oe_n});
    // crossings on all phases once the 512 tick mask has run out
    loopback_raw = 1'b0;
    wr_sys(12'h070);
    step();
    repeat (1100) @(negedge mclk);
    zero_cross_raw = 3'h7;
    repeat (8) @(negedge mclk);
    note("detect", 12'h001, {10'h0, zero_cross_detect_oe_n, zero_cross_detect_output});
    u_ssrb_host.read_frame(4'h2, rd);
    note("status", 12'h04f, rd);
    // single phase mode sees phase a only
    wr_sys(12'h078);
    step();
    repeat (1100) @(negedge mclk);
    zero_cross_raw = 3'h0;
    repeat (8) @(negedge mclk);
    u_ssrb_host.read_frame(4'h2, rd);
    note("status", 12'h059, rd);
    // doubled mask still blinds a crossing 700 ticks after the step
    wr_sys(12'h278);
    step();
    repeat (700) @(negedge mclk);
    zero_cross_raw = 3'h1;
    repeat (8) @(negedge mclk);
    u_ssrb_host.read_frame(4'h2, rd);
    note("status", 12'h050, rd);
    // power-on reset clears both writable registers
    u_ssrb_host.write_frame(4'h0, 12'h1a5, 16);
    note("spin", 12'h1a5, spin_obs);
    por_n = 1'b0;
    repeat (10) @(negedge mclk);
    por_n = 1'b1;
    repeat (8) @(negedge mclk);
    note("spin", 12'h000, spin_obs);
    note("sys", 12'h000, sys_obs);
    @(negedge mclk);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
